// file: tb/deser_link_and_i2c_config_regs_tb.sv
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Watchdog unit shortened to 4 clocks
// Notes:   Filter checks watch for any excursion from idle
`timescale 1ns/100ps
module deser_link_and_i2c_config_regs_tb;
    localparam int         UNIT   = 4;
    localparam logic [4:0] IDLE_O = 5'h18;
    // Bench-driven inputs and the read data
    logic        clk, rst_n, wr_en, rd_en, dual, prot, match, wreq, lock;
    logic [7:0]  addr, wdata, rdata;
    logic [6:0]  far_addr;
    // Model pins and design outputs
    logic [4:0]  pins, outs;
    logic [23:0] color, color_out;
    logic        txn, abort, crc_on, pull_sel, fwd, ack;
    int          fails, n_compared;

    deser_link_and_i2c_config_regs #(.WDT_UNIT_CYCLES(UNIT)) DUT (
        .clk(clk), .rst_n(rst_n),
        .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata),
        .return_path_check_gen_on(crc_on),
        .undriven_input_pull_select(pull_sel),
        .data_valid_strobe_in(pins[0]), .horizontal_sync_in(pins[1]),
        .vertical_sync_in(pins[2]), .color_in(color),
        .dual_link_mode(dual), .far_has_protection(prot),
        .data_valid_strobe(outs[0]), .horizontal_sync(outs[1]),
        .vertical_sync(outs[2]), .color_out(color_out),
        .scl_in(pins[3]), .sda_in(pins[4]),
        .scl_filt(outs[3]), .sda_held(outs[4]),
        .i2c_addr_match(match), .i2c_write_req(wreq), .fwd_lock(lock),
        .far_serializer_address(far_addr),
        .fwd_to_far(fwd), .write_ack(ack),
        .ctrl_txn_active(txn), .ctrl_txn_abort(abort)
    );

    far_side_model far (
        .clk(clk), .pins(pins), .txn_active(txn), .color(color)
    );

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // Access and compare tasks
    // ---------------------------------------------------------------
    task automatic check(input string nm, input logic [23:0] exp,
                         input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data lands on the edge that takes the request
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check("reg_rdata", exp, rdata);
    endtask

    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // Pulse one pin and note whether its filtered copy ever moved
    task automatic try(input int sel, input int len, input logic exp);
        logic seen;
        seen = 1'b0;
        fork
            far.pulse(sel, len);
            repeat (len + 12) begin
                @(posedge clk);
                #1;
                if (outs[sel] !== IDLE_O[sel]) seen = 1'b1;
            end
        join
        check("filtered pin moved", exp, seen);
    endtask

    // Count abort pulses over one transaction
    task automatic wdog(input int len, input int exp);
        int n;
        n = 0;
        fork
            far.txn(len);
            repeat (len + 6) begin
                @(posedge clk);
                #1;
                if (abort === 1'b1) n++;
            end
        join
        check("ctrl_txn_abort count", exp, n);
    endtask

    task automatic route(input logic m, input logic [6:0] fa,
                         input logic exp);
        @(posedge clk);
        match    <= m;
        far_addr <= fa;
        settle;
        check("fwd_to_far", exp, fwd);
    endtask

    task automatic give_verdict;
        if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {rst_n, wr_en, rd_en, dual, prot, match, wreq, lock} = 8'h00;
        addr = 8'h00;
        wdata = 8'h00;
        far_addr = 7'h00;
        fails = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values and reserved places
        rd(8'h03, 8'h70);
        rd(8'h04, 8'hfe);
        rd(8'h05, 8'h1e);
        rd(8'h06, 8'h00);
        check("crc_gen", 1'b1, crc_on);
        check("pull_sel", 1'b1, pull_sel);
        wr(8'h03, 8'hff);
        rd(8'h03, 8'h7e);
        wr(8'h06, 8'hff);
        rd(8'h06, 8'h00);
        wr(8'h03, 8'h00);
        settle;
        check("crc_gen", 1'b0, crc_on);
        check("pull_sel", 1'b0, pull_sel);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'hff);
        wr(8'h05, 8'ha5);
        rd(8'h05, 8'ha5);
        wr(8'h05, 8'h1e);
        // Video sync filter, single then dual link
        wr(8'h03, 8'h10);
        try(0, 1, 1'b0);
        try(0, 2, 1'b1);
        try(2, 1, 1'b0);
        try(1, 1, 1'b0);
        dual <= 1'b1;
        try(1, 3, 1'b0);
        try(1, 5, 1'b1);
        dual <= 1'b0;
        wr(8'h03, 8'h00);
        try(0, 1, 1'b1);
        // Serial glitch filter and hold path
        try(3, 2, 1'b0);
        try(3, 8, 1'b1);
        try(4, 8, 1'b1);
        // Forward decision
        route(1'b1, 7'h12, 1'b0);
        wr(8'h03, 8'h08);
        route(1'b1, 7'h12, 1'b1);
        route(1'b1, 7'h00, 1'b0);
        route(1'b0, 7'h12, 1'b0);
        wr(8'h03, 8'h00);
        wr(8'h05, 8'h9e);
        route(1'b0, 7'h12, 1'b1);
        route(1'b0, 7'h00, 1'b0);
        wr(8'h05, 8'h1e);
        // Write acknowledge: none, then auto-ack without lock, then forward lock alone
        wreq <= 1'b1;
        settle;
        check("write_ack", 1'b0, ack);
        wr(8'h03, 8'h04);
        settle;
        check("write_ack", 1'b1, ack);
        wr(8'h03, 8'h00);
        lock <= 1'b1;
        settle;
        check("write_ack", 1'b1, ack);
        // Colour gating; valid stays low throughout
        settle;
        check("color_out", 24'h5ac396, color_out);
        wr(8'h03, 8'h02);
        settle;
        check("color_out", 24'h000000, color_out);
        wr(8'h03, 8'h00);
        prot <= 1'b1;
        settle;
        check("color_out", 24'h000000, color_out);
        // Watchdog: field 2 of 4-clock units, then disabled
        wr(8'h04, 8'h04);
        wdog(30, 1);
        wdog(6, 0);
        wr(8'h04, 8'h05);
        wdog(30, 0);
        give_verdict;
    end

    // Hang guard, well past the expected run of about 350 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict;
    end
endmodule

// file: tb/far_side_model.sv
// Purpose: Far-side stand-in for video, serial and channel pins
// Assumes: Pins change only just after a rising clk edge
// Notes:   Idle levels: video low, serial lines high (pulled up)
`timescale 1ns/100ps
module far_side_model (
    // Clock
    input  wire logic        clk,
    // Driven pins: sda, scl, vsync, hsync, valid
    output logic      [4:0]  pins,
    output logic             txn_active,
    output logic      [23:0] color
);
    localparam logic [4:0] IDLE = 5'h18;

    // Park at idle; colour word fixed so gating shows plainly
    initial begin
        pins = IDLE;
        txn_active = 1'b0;
        color = 24'h5ac396;
    end

    // Hold one pin away from idle for len sampling edges
    task automatic pulse(input int sel, input int len);
        @(posedge clk);
        pins[sel] <= ~IDLE[sel];
        repeat (len) @(posedge clk);
        pins[sel] <= IDLE[sel];
    endtask

    // Keep a channel transaction open for len edges
    task automatic txn(input int len);
        @(posedge clk);
        txn_active <= 1'b1;
        repeat (len) @(posedge clk);
        txn_active <= 1'b0;
    endtask
endmodule

// file: verilog/deser_cfg_pkg.sv
// Purpose: Constants for the link and serial-port configuration bank
// Assumes: 50 MHz core clock, byte-wide register port
// Notes:   Derived cycle counts are computed from the printed figures
package deser_cfg_pkg;

    // ------------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_LINK_OPT   = 8'h03;
    localparam logic [7:0] OFS_TIMEOUT    = 8'h04;
    localparam logic [7:0] OFS_TUNING     = 8'h05;
    localparam logic [7:0] RST_LINK_OPT   = 8'h70;
    localparam logic [7:0] RST_TIMEOUT    = 8'hfe;
    localparam logic [7:0] RST_TUNING     = 8'h1e;
    localparam logic [7:0] LINK_OPT_WMASK = 8'h7e; // Bits 7 and 0 reserved

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int B_CRC_GEN   = 6;
    localparam int B_PULL_SEL  = 5;
    localparam int B_SYNC_FILT = 4;
    localparam int B_PASS      = 3;
    localparam int B_AUTO_ACK  = 2;
    localparam int B_GATE      = 1;
    localparam int B_WDT_OFF   = 0;
    localparam int TO_MSB      = 7;
    localparam int TO_LSB      = 1;
    localparam int B_PASS_ALL  = 7;
    localparam int HOLD_MSB    = 6;
    localparam int HOLD_LSB    = 4;
    localparam int DEPTH_MSB   = 3;
    localparam int DEPTH_LSB   = 0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 50_000_000;
    localparam int CLK_PERIOD_NS   = 20;
    localparam int WDT_STEP_MS     = 2;
    localparam int WDT_UNIT_CYCLES = CLK_HZ / 1000 * WDT_STEP_MS;
    localparam int HOLD_STEP_NS    = 50;
    localparam int GLITCH_STEP_NS  = 5;
    localparam int HOLD_MAX        = 7;
    localparam int HOLD_TAPS       =
        (HOLD_MAX * HOLD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SYNC_REJ_CYC    = 3'h2;
    localparam logic [2:0] HS_DUAL_REJ_CYC = 3'h4;

endpackage

// file: verilog/deser_link_and_i2c_config_regs.sv
// Purpose: Link options, control-channel timeout and serial-port tuning
// Assumes: Register port already decoded from the serial control port;
//          pixel inputs are sampled on clk
// Notes:   Video and serial pins pass two flip-flops before any filter
//
// What this block does
// - Back-channel CRC generation follows its enable bit
// - Pull select bit: one pulls down, zero up
// - Sync filter rejects pulses under two clocks
// - Horizontal sync filter: two single, four dual
// - Pass-through forwards matching transactions to serializer
// - Auto-acknowledge writes regardless of forward lock
// - Colour gated always if protected, else bit
// - Watchdog terminates overlong control-channel transactions
// - Timeout is bits 7-1, 2 ms steps
// - Watchdog disable bit stops the timer
// - Pass-all bit forwards every transaction while far address is nonzero
// - Serial data hold time in 50 ns steps
// - Serial glitch filter depth in 5 ns steps
// - Zero far address blocks remote access
`timescale 1ns/100ps
module deser_link_and_i2c_config_regs #(
    parameter int WDT_UNIT_CYCLES = deser_cfg_pkg::WDT_UNIT_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Static link options
    output logic             return_path_check_gen_on,
    output logic             undriven_input_pull_select,
    // Video pins and link status
    input  wire logic        data_valid_strobe_in,
    input  wire logic        horizontal_sync_in,
    input  wire logic        vertical_sync_in,
    input  wire logic [23:0] color_in,
    input  wire logic        dual_link_mode,
    input  wire logic        far_has_protection,
    // Filtered video
    output logic             data_valid_strobe,
    output logic             horizontal_sync,
    output logic             vertical_sync,
    output logic      [23:0] color_out,
    // Serial control pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             scl_filt,
    output logic             sda_held,
    // Transaction routing
    input  wire logic        i2c_addr_match,
    input  wire logic        i2c_write_req,
    input  wire logic        fwd_lock,
    input  wire logic [6:0]  far_serializer_address,
    output logic             fwd_to_far,
    output logic             write_ack,
    // Control-channel watchdog
    input  wire logic        ctrl_txn_active,
    output logic             ctrl_txn_abort
);

    localparam int NCH = 5; // de, hs, vs, scl, sda

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] link_general_options_q;
    logic [7:0] ctrl_channel_timeout_q;
    logic [7:0] serial_port_tuning_q;

    // Software writes; reserved bits masked on the way in
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_general_options_q <= deser_cfg_pkg::RST_LINK_OPT;
            ctrl_channel_timeout_q <= deser_cfg_pkg::RST_TIMEOUT;
            serial_port_tuning_q   <= deser_cfg_pkg::RST_TUNING;
        end else if (reg_wr_en) begin
            if (reg_addr == deser_cfg_pkg::OFS_LINK_OPT)
                link_general_options_q <=
                    reg_wdata & deser_cfg_pkg::LINK_OPT_WMASK;
            if (reg_addr == deser_cfg_pkg::OFS_TIMEOUT)
                ctrl_channel_timeout_q <= reg_wdata;
            if (reg_addr == deser_cfg_pkg::OFS_TUNING)
                serial_port_tuning_q <= reg_wdata;
        end
    end

    // Read data registered; unmapped offsets answer zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd_en) begin
            unique case (reg_addr)
                deser_cfg_pkg::OFS_LINK_OPT:
                    reg_rdata <= link_general_options_q;
                deser_cfg_pkg::OFS_TIMEOUT:
                    reg_rdata <= ctrl_channel_timeout_q;
                deser_cfg_pkg::OFS_TUNING:
                    reg_rdata <= serial_port_tuning_q;
                default:                     reg_rdata <= 8'h00;
            endcase
        end
    end

    // Field views
    logic       sync_filt_on;
    logic       pass_on;
    logic       auto_ack_on;
    logic       gate_color_by_valid;
    logic [6:0] ctrl_channel_timeout_value;
    logic       ctrl_channel_timeout_off;
    logic       pass_all_on;
    logic [2:0] hold_sel;
    logic [3:0] depth_sel;

    assign sync_filt_on = link_general_options_q[deser_cfg_pkg::B_SYNC_FILT];
    assign pass_on      = link_general_options_q[deser_cfg_pkg::B_PASS];
    assign auto_ack_on  = link_general_options_q[deser_cfg_pkg::B_AUTO_ACK];
    assign gate_color_by_valid =
        link_general_options_q[deser_cfg_pkg::B_GATE];
    assign ctrl_channel_timeout_value = ctrl_channel_timeout_q[
        deser_cfg_pkg::TO_MSB:deser_cfg_pkg::TO_LSB];
    assign ctrl_channel_timeout_off =
        ctrl_channel_timeout_q[deser_cfg_pkg::B_WDT_OFF];
    assign pass_all_on = serial_port_tuning_q[deser_cfg_pkg::B_PASS_ALL];
    assign hold_sel    = serial_port_tuning_q[
        deser_cfg_pkg::HOLD_MSB:deser_cfg_pkg::HOLD_LSB];
    assign depth_sel   = serial_port_tuning_q[
        deser_cfg_pkg::DEPTH_MSB:deser_cfg_pkg::DEPTH_LSB];

    // ------------------------------------------------------------------
    // Static option outputs
    // ------------------------------------------------------------------
    // Registered copies keep outputs straight from flip-flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            return_path_check_gen_on   <= 1'b1;
            undriven_input_pull_select <= 1'b1;
        end else begin
            return_path_check_gen_on <=
                link_general_options_q[deser_cfg_pkg::B_CRC_GEN];
            undriven_input_pull_select <=
                link_general_options_q[deser_cfg_pkg::B_PULL_SEL];
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers and pulse filters
    // ------------------------------------------------------------------
    logic [NCH-1:0] pin_raw;
    logic [NCH-1:0] pin_s1_q;
    logic [NCH-1:0] pin_s2_q;
    logic [NCH-1:0] filt_q;
    logic [2:0]     need [NCH];
    logic [2:0]     glitch_need;
    logic [23:0]    color_s1_q;
    logic [23:0]    color_s2_q;
    // Serial lines idle high; resetting low would fake an edge
    localparam logic [NCH-1:0] PIN_IDLE = 5'h18;

    assign pin_raw = {sda_in, scl_in, vertical_sync_in,
                      horizontal_sync_in, data_valid_strobe_in};

    // Two stages; only the second stage is read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_q   <= PIN_IDLE;
            pin_s2_q   <= PIN_IDLE;
            color_s1_q <= 24'h000000;
            color_s2_q <= 24'h000000;
        end else begin
            pin_s1_q   <= pin_raw;
            pin_s2_q   <= pin_s1_q;
            color_s1_q <= color_in;
            color_s2_q <= color_s1_q;
        end
    end

    // glitch depth to cycles
    // Floor plus one so a pulse of the set width never passes
    assign glitch_need = 3'((10'(depth_sel)
        * 10'(deser_cfg_pkg::GLITCH_STEP_NS))
        / 10'(deser_cfg_pkg::CLK_PERIOD_NS) + 10'h001);

    // Cycles an input must hold before the output follows
    always_comb begin
        need[0] = sync_filt_on ? deser_cfg_pkg::SYNC_REJ_CYC : 3'h1;
        need[1] = !sync_filt_on ? 3'h1 :
                  dual_link_mode ? deser_cfg_pkg::HS_DUAL_REJ_CYC :
                                   deser_cfg_pkg::SYNC_REJ_CYC;
        need[2] = need[0];
        need[3] = glitch_need;
        need[4] = glitch_need;
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_filt
            logic [2:0] run_q;
            // Output flips after need cycles of disagreement
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    run_q       <= 3'h0;
                    filt_q[ch]  <= PIN_IDLE[ch];
                end else if (pin_s2_q[ch] == filt_q[ch]) begin
                    run_q <= 3'h0;
                end else if (run_q + 3'h1 >= need[ch]) begin
                    run_q      <= 3'h0;
                    filt_q[ch] <= pin_s2_q[ch];
                end else begin
                    run_q <= run_q + 3'h1;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Video outputs and colour gating
    // ------------------------------------------------------------------
    logic gate_now;
    assign gate_now = far_has_protection | gate_color_by_valid;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_valid_strobe <= 1'b0;
            horizontal_sync   <= 1'b0;
            vertical_sync     <= 1'b0;
            color_out         <= 24'h000000;
        end else begin
            data_valid_strobe <= filt_q[0];
            horizontal_sync   <= filt_q[1];
            vertical_sync     <= filt_q[2];
            color_out <= (gate_now && !filt_q[0]) ? 24'h000000 : color_s2_q;
        end
    end

    // ------------------------------------------------------------------
    // Serial clock and data hold
    // ------------------------------------------------------------------
    logic [deser_cfg_pkg::HOLD_TAPS-1:0] sda_dly_q;
    logic [4:0]                          hold_cyc;

    // hold time to cycles
    // Rounded up so the hold is never shorter than asked
    // Ten bits: seven steps of 50 ns overflow a byte
    assign hold_cyc = 5'((10'(hold_sel) * 10'(deser_cfg_pkg::HOLD_STEP_NS)
        + 10'(deser_cfg_pkg::CLK_PERIOD_NS - 1))
        / 10'(deser_cfg_pkg::CLK_PERIOD_NS));

    // Data delayed behind the clock by the selected tap
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sda_dly_q <= '1;
            scl_filt  <= 1'b1;
            sda_held  <= 1'b1;
        end else begin
            sda_dly_q <= {sda_dly_q[deser_cfg_pkg::HOLD_TAPS-2:0], filt_q[4]};
            scl_filt  <= filt_q[3];
            sda_held  <= (hold_cyc == 5'h00) ? filt_q[4]
                                             : sda_dly_q[hold_cyc - 5'h01];
        end
    end

    // ------------------------------------------------------------------
    // Transaction routing
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fwd_to_far <= 1'b0;
            write_ack  <= 1'b0;
        end else begin
            fwd_to_far <= (far_serializer_address != 7'h00) &&
                          (pass_all_on || (pass_on && i2c_addr_match));
            write_ack  <= i2c_write_req && (fwd_lock || auto_ack_on);
        end
    end

    // ------------------------------------------------------------------
    // Control-channel watchdog
    // ------------------------------------------------------------------
    logic [31:0] pre_q;
    logic [6:0]  units_q;
    logic        expired_q;
    logic        unit_tick;

    assign unit_tick = (pre_q == 32'(WDT_UNIT_CYCLES - 1));

    // timeout counting
    // One abort per transaction; rearms when activity drops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_q          <= 32'h0;
            units_q        <= 7'h00;
            expired_q      <= 1'b0;
            ctrl_txn_abort <= 1'b0;
        end else if (!ctrl_txn_active || ctrl_channel_timeout_off) begin
            pre_q          <= 32'h0;
            units_q        <= 7'h00;
            expired_q      <= 1'b0;
            ctrl_txn_abort <= 1'b0;
        end else begin
            pre_q          <= unit_tick ? 32'h0 : pre_q + 32'h1;
            ctrl_txn_abort <= 1'b0;
            if (unit_tick && !expired_q) begin
                units_q <= units_q + 7'h01;
                if (units_q + 7'h01 == ctrl_channel_timeout_value) begin
                    expired_q      <= 1'b1;
                    ctrl_txn_abort <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence wr_link_s;
        reg_wr_en && reg_addr == deser_cfg_pkg::OFS_LINK_OPT;
    endsequence

    sequence pin_pulse1_s;
        !pin_s2_q[0] ##1 pin_s2_q[0] ##1 !pin_s2_q[0];
    endsequence

    reserved_zero_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        wr_link_s |=> link_general_options_q[7] == 1'b0 &&
                      link_general_options_q[0] == 1'b0)
        else $error("reserved link option bit set");
    crc_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 return_path_check_gen_on ==
            $past(link_general_options_q[deser_cfg_pkg::B_CRC_GEN]))
        else $error("crc enable output stale");
    pull_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_link_s ##1 1'b1 |=> undriven_input_pull_select ==
            $past(reg_wdata[deser_cfg_pkg::B_PULL_SEL], 2))
        else $error("pull select did not follow write");
    short_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        sync_filt_on && !filt_q[0] ##0 pin_pulse1_s ##0 sync_filt_on
        |=> !filt_q[0])
        else $error("one cycle valid pulse passed filter");
    hs_dual_a: assert property (@(posedge clk) disable iff (!rst_n)
        sync_filt_on && dual_link_mode && $rose(pin_s2_q[1]) && !filt_q[1]
        ##1 (sync_filt_on && dual_link_mode) [*2] |=> !filt_q[1])
        else $error("hsync passed dual filter early");
    fwd_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        far_serializer_address == 7'h00 |=> !fwd_to_far)
        else $error("forward with zero far address");
    pass_all_a: assert property (@(posedge clk) disable iff (!rst_n)
        pass_all_on && far_serializer_address != 7'h00 |=> fwd_to_far)
        else $error("pass all did not forward");
    auto_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
        i2c_write_req && auto_ack_on && !fwd_lock |=> write_ack)
        else $error("auto ack missing");
    gate_prot_a: assert property (@(posedge clk) disable iff (!rst_n)
        far_has_protection && !filt_q[0] |=> color_out == 24'h000000)
        else $error("colour not gated when protected");
    wdt_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_channel_timeout_off |=> !ctrl_txn_abort && units_q == 7'h00)
        else $error("watchdog ran while disabled");
    abort_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_txn_abort |=> !ctrl_txn_abort)
        else $error("abort longer than one cycle");

endmodule
